// >>> common/isr_pkg.sv
// constants shared by both ends of the isolated serial relay
// assumes a single system clock of 125 MHz on both ends
package isr_pkg;
   // ****************************************
   // clock and timing figures
   // ****************************************
   localparam int CLK_NS = 8;
   localparam int FAST_MAX_NS = 14;
   localparam int GLITCH_NS = 10;
   localparam int SEL_SETUP_NS = 10;
   localparam int EXCH_HALF_NS = 1250;
   localparam int DELIVER_NS = 100;
   localparam int REFRESH_NS = 1200;
   localparam int WATCHDOG_NS = 5000;
   localparam int SLOW_MIN_NS = 2500;
   // least times round up, longest times round down
   localparam int FAST_MAX_CYC = FAST_MAX_NS / CLK_NS;
   localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int SEL_SETUP_CYC = (SEL_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int EXCH_HALF_CYC = EXCH_HALF_NS / CLK_NS;
   localparam int DELIVER_CYC = DELIVER_NS / CLK_NS;
   localparam int REFRESH_CYC = (REFRESH_NS + CLK_NS - 1) / CLK_NS;
   localparam int WATCHDOG_CYC = (WATCHDOG_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLOW_MIN_CYC = (2 * SLOW_MIN_NS + CLK_NS - 1) / CLK_NS;
   // ****************************************
   // fast channel indices and host defaults
   // ****************************************
   localparam int CH_CLK = 0;
   localparam int CH_DATA = 1;
   localparam int CH_SEL = 2;
   localparam int CH_RET = 3;
   localparam int NUM_CH = 4;
   localparam int WORD_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int SCK_HALF_CYC = 8;
   localparam logic SEL_IDLE = 1'b1;
   typedef enum logic [1:0] {
      ISR_IDLE = 2'b00,
      ISR_SETUP = 2'b01,
      ISR_SHIFT = 2'b11,
      ISR_DRAIN = 2'b10
   } isr_host_state_t;
endpackage

// >>> common/isr_link_if.sv
// host-side pins of the isolated relay, joining host controller and relay
// assumes both parties sample these through their own synchronisers
`timescale 1ns/1ps
interface isr_link_if;
   logic host_clk;
   logic host_data_out;
   logic host_select_in_n;
   logic host_data_return;
   logic delayed_return_clock;
   logic slow_input_a;
   logic slow_output_b;
   logic slow_output_b_en;
   modport dev (
      input host_clk,
      input host_data_out,
      input host_select_in_n,
      input slow_input_a,
      output host_data_return,
      output delayed_return_clock,
      output slow_output_b,
      output slow_output_b_en
   );
   modport host (
      output host_clk,
      output host_data_out,
      output host_select_in_n,
      output slow_input_a,
      input host_data_return,
      input delayed_return_clock,
      input slow_output_b,
      input slow_output_b_en
   );
endinterface

// >>> rtl/isr_relay.sv
// logic model of the isolated relay: fast paths, slow exchange, delayed clock
// assumes host pins arrive on the link interface and far pins are plain ports
`timescale 1ns/1ps
module isr_relay #(
   parameter bit FILTER_GRADE = 1'b1,
   parameter int EXCH_HALF = isr_pkg::EXCH_HALF_CYC,
   parameter int GLITCH = isr_pkg::GLITCH_CYC,
   parameter int WATCHDOG = isr_pkg::WATCHDOG_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   isr_link_if.dev link,
   output logic far_clk,
   output logic far_data_drive,
   output logic far_select_out_n,
   input wire logic far_data_return,
   output logic slow_output_a,
   output logic far_out_en,
   input wire logic slow_input_b,
   input wire logic far_powered
);
   // ****************************************
   // derived delays
   // ****************************************
   // grade and delays as parameters
   localparam int FW_DATA = FILTER_GRADE ? GLITCH : 0;
   localparam int PATH_LAT = 3 + FW_DATA;
   localparam int DELAYED_RETURN_CLOCK_DLY = 2 * PATH_LAT;
   localparam int PH_W = $clog2(2 * EXCH_HALF);
   localparam int WD_W = $clog2(WATCHDOG + 1);
   localparam int ID_W = $clog2(isr_pkg::REFRESH_CYC + 1);
   localparam logic [PH_W-1:0] PH_LAST = PH_W'(2 * EXCH_HALF - 1);
   localparam logic [PH_W-1:0] PH_B = PH_W'(EXCH_HALF);
   localparam logic [PH_W-1:0] PH_DA = PH_W'(isr_pkg::DELIVER_CYC);
   localparam logic [PH_W-1:0] PH_DB = PH_W'(EXCH_HALF + isr_pkg::DELIVER_CYC);
   localparam logic [ID_W-1:0] IDLE_LIM = ID_W'(isr_pkg::REFRESH_CYC);
   localparam logic [WD_W-1:0] WD_LIM = WD_W'(WATCHDOG);

   // ****************************************
   // pin synchronisers for slow inputs
   // ****************************************
   logic sa1_reg, sa2_reg, sb1_reg, sb2_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sa1_reg <= 1'b0;
         sa2_reg <= 1'b0;
         sb1_reg <= 1'b0;
         sb2_reg <= 1'b0;
      end else begin
         sa1_reg <= link.slow_input_a;
         sa2_reg <= sa1_reg;
         sb1_reg <= slow_input_b;
         sb2_reg <= sb1_reg;
      end
   end

   // ****************************************
   // free-running exchange sequencer
   // ****************************************
   logic [PH_W-1:0] ph_reg;
   wire ph_wrap = (ph_reg == PH_LAST);
   wire samp_a = (ph_reg == '0);
   wire deliv_a = (ph_reg == PH_DA);
   wire samp_b = (ph_reg == PH_B) && far_powered;
   wire deliv_b = (ph_reg == PH_DB) && far_powered;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) ph_reg <= '0;
      else ph_reg <= ph_wrap ? '0 : ph_reg + 1'b1;
   end

   // ****************************************
   // fast channels, one per relayed signal
   // ****************************************
   wire [3:0] ch_in = {far_data_return, link.host_select_in_n, link.host_data_out,
      link.host_clk};
   wire [3:0] ch_out;
   wire [3:0] ch_lvl;
   logic [3:0] pkt_reg;
   wire [3:0] ch_deliv = {deliv_b, deliv_a, deliv_a, deliv_a};
   genvar g;
   for (g = 0; g < isr_pkg::NUM_CH; g++) begin : g_ch
      localparam int FW = (g == isr_pkg::CH_SEL) ? GLITCH : FW_DATA;
      localparam logic [3:0] FW_L = 4'(FW);
      // reset to the pin's idle level, so no false select edge follows reset
      localparam logic IDLE_L = (g == isr_pkg::CH_SEL) ? isr_pkg::SEL_IDLE : 1'b0;
      logic s1_reg, s2_reg, cand_reg, out_reg;
      logic [3:0] cnt_reg;
      logic [ID_W-1:0] idle_reg;
      wire changed = (s2_reg != cand_reg);
      wire settled = !changed && (cnt_reg == FW_L);
      // refresh only after a quiet input
      wire refresh = ch_deliv[g] && (idle_reg == IDLE_LIM) && (out_reg != pkt_reg[g]);
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            s1_reg <= IDLE_L;
            s2_reg <= IDLE_L;
         end else begin
            s1_reg <= ch_in[g];
            s2_reg <= s1_reg;
         end
      end
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            cand_reg <= IDLE_L;
            cnt_reg <= 4'h0;
         end else if (changed) begin
            cand_reg <= s2_reg;
            cnt_reg <= 4'h0;
         end else if (cnt_reg != FW_L) begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            out_reg <= IDLE_L;
            idle_reg <= '0;
         end else begin
            idle_reg <= changed ? '0 : (idle_reg == IDLE_LIM ? idle_reg : idle_reg + 1'b1);
            if (refresh) out_reg <= pkt_reg[g];
            else if (settled) out_reg <= cand_reg;
         end
      end
      assign ch_out[g] = out_reg;
      assign ch_lvl[g] = s2_reg;
   end

   // ****************************************
   // slow channels and packets
   // ****************************************
   logic slow_a_pkt_reg, slow_b_pkt_reg, slow_a_reg, slow_b_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pkt_reg <= 4'b0100;
         slow_a_pkt_reg <= 1'b0;
         slow_b_pkt_reg <= 1'b0;
         slow_a_reg <= 1'b0;
         slow_b_reg <= 1'b0;
      end else begin
         if (samp_a) begin
            pkt_reg[2:0] <= ch_lvl[2:0];
            slow_a_pkt_reg <= sa2_reg;
         end
         if (samp_b) begin
            pkt_reg[3] <= ch_lvl[3];
            slow_b_pkt_reg <= sb2_reg;
         end
         // output follows sample by deliver delay
         if (deliv_a) slow_a_reg <= slow_a_pkt_reg;
         if (deliv_b) slow_b_reg <= slow_b_pkt_reg;
      end
   end

   // ****************************************
   // receive watchdogs per side
   // ****************************************
   logic [WD_W-1:0] wd_a_reg, wd_b_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wd_a_reg <= '0;
         wd_b_reg <= '0;
      end else begin
         wd_a_reg <= deliv_a ? '0 : (wd_a_reg == WD_LIM ? wd_a_reg : wd_a_reg + 1'b1);
         wd_b_reg <= deliv_b ? '0 : (wd_b_reg == WD_LIM ? wd_b_reg : wd_b_reg + 1'b1);
      end
   end

   // ****************************************
   // delayed clock line
   // ****************************************
   logic [DELAYED_RETURN_CLOCK_DLY-1:0] dly_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) dly_reg <= '0;
      // clock copy delayed by round trip
      else dly_reg <= {dly_reg[DELAYED_RETURN_CLOCK_DLY-2:0], ch_lvl[isr_pkg::CH_CLK]};
   end

   // ****************************************
   // outputs
   // ****************************************
   // forward and return relays
   assign far_clk = ch_out[isr_pkg::CH_CLK];
   assign far_data_drive = ch_out[isr_pkg::CH_DATA];
   assign far_select_out_n = ch_out[isr_pkg::CH_SEL];
   assign link.host_data_return = ch_out[isr_pkg::CH_RET];
   assign link.delayed_return_clock = dly_reg[DELAYED_RETURN_CLOCK_DLY-1];
   assign slow_output_a = slow_a_reg;
   assign link.slow_output_b = slow_b_reg;
   assign far_out_en = (wd_a_reg != WD_LIM);
   assign link.slow_output_b_en = (wd_b_reg != WD_LIM);
endmodule // isr_relay

// >>> rtl/isr_host.sv
// host controller end: drives the relay's host pins, captures return data
// assumes clk_sys is the host clock and the relay sits on the link interface
`timescale 1ns/1ps
module isr_fifo #(
   parameter int WIDTH = isr_pkg::WORD_W,
   parameter int DEPTH = isr_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, rd_reg;
   logic [AW:0] cnt_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_reg != FULL);
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_reg];
   // storage written without reset
   always_ff @(posedge clk_sys) begin
      if (push) mem[wr_reg] <= in_data;
   end
   // pointers wrap at depth
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         if (pop) rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
      end
   end
endmodule // isr_fifo

module isr_host #(
   parameter int HALF = isr_pkg::SCK_HALF_CYC,
   parameter int SLOW_MIN = isr_pkg::SLOW_MIN_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   isr_link_if.host link,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [isr_pkg::WORD_W-1:0] tx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [isr_pkg::WORD_W-1:0] rx_data,
   input wire logic slow_a_req,
   output logic slow_b_level,
   output logic slow_b_valid
);
   localparam int W = isr_pkg::WORD_W;
   localparam logic [7:0] HALF_L = 8'(HALF - 1);
   localparam logic [7:0] SETUP_L = 8'(isr_pkg::SEL_SETUP_CYC);
   localparam logic [3:0] BITS = 4'(W);
   localparam logic [15:0] SLOW_L = 16'(SLOW_MIN);
   isr_pkg::isr_host_state_t st_reg, st_next;
   logic [7:0] tm_reg;
   logic [3:0] edge_reg, cap_reg;
   logic [W-1:0] sh_reg, rxs_reg;
   logic sck_reg, sel_reg, push_reg;
   logic d1_reg, d2_reg, d3_reg, r1_reg, r2_reg, b1_reg, b2_reg, e1_reg, e2_reg;
   logic sa_reg;
   logic [15:0] hold_reg;
   wire fifo_ready;
   // no new word while the last captured word is still on its way into the buffer
   wire room = fifo_ready && !push_reg;
   wire tm_done = (tm_reg == '0);
   wire delayed_return_clock_rise = d2_reg && !d3_reg;
   wire all_sent = (edge_reg == BITS);
   wire all_cap = (cap_reg == BITS);
   assign tx_ready = (st_reg == isr_pkg::ISR_IDLE) && room;

   // ****************************************
   // transfer state machine
   // ****************************************
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         isr_pkg::ISR_IDLE: if (tx_valid && room) st_next = isr_pkg::ISR_SETUP;
         isr_pkg::ISR_SETUP: if (tm_done) st_next = isr_pkg::ISR_SHIFT;
         isr_pkg::ISR_SHIFT: if (tm_done && sck_reg && all_sent) st_next = isr_pkg::ISR_DRAIN;
         isr_pkg::ISR_DRAIN: if (all_cap) st_next = isr_pkg::ISR_IDLE;
         default: st_next = isr_pkg::ISR_IDLE;
      endcase
   end

   // ****************************************
   // clock divider and shifter
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg <= isr_pkg::ISR_IDLE;
         tm_reg <= '0;
         sck_reg <= 1'b0;
         sel_reg <= isr_pkg::SEL_IDLE;
         sh_reg <= '0;
         edge_reg <= '0;
      end else begin
         st_reg <= st_next;
         tm_reg <= tm_done ? '0 : tm_reg - 8'h01;
         if (st_reg == isr_pkg::ISR_IDLE && st_next == isr_pkg::ISR_SETUP) begin
            sel_reg <= 1'b0;
            sh_reg <= tx_data;
            edge_reg <= '0;
            tm_reg <= (HALF_L > SETUP_L) ? HALF_L : SETUP_L;
         end else if (st_reg == isr_pkg::ISR_SHIFT && tm_done) begin
            tm_reg <= HALF_L;
            sck_reg <= !sck_reg;
            if (sck_reg) sh_reg <= {sh_reg[W-2:0], 1'b0};
            else edge_reg <= edge_reg + 4'h1;
         end
         if (st_reg == isr_pkg::ISR_DRAIN && all_cap) sel_reg <= isr_pkg::SEL_IDLE;
         if (st_next == isr_pkg::ISR_DRAIN) sck_reg <= 1'b0;
      end
   end

   // ****************************************
   // secondary receive buffer on delayed clock
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         d1_reg <= 1'b0;
         d2_reg <= 1'b0;
         d3_reg <= 1'b0;
         r1_reg <= 1'b0;
         r2_reg <= 1'b0;
         rxs_reg <= '0;
         cap_reg <= '0;
         push_reg <= 1'b0;
      end else begin
         d1_reg <= link.delayed_return_clock;
         d2_reg <= d1_reg;
         d3_reg <= d2_reg;
         r1_reg <= link.host_data_return;
         r2_reg <= r1_reg;
         push_reg <= (st_reg == isr_pkg::ISR_DRAIN) && all_cap;
         if (st_reg == isr_pkg::ISR_SETUP) cap_reg <= '0;
         else if (delayed_return_clock_rise && !sel_reg && !all_cap) begin
            rxs_reg <= {rxs_reg[W-2:0], r2_reg};
            cap_reg <= cap_reg + 4'h1;
         end
      end
   end

   isr_fifo #(.WIDTH(W), .DEPTH(isr_pkg::FIFO_DEPTH)) isr_fifo_inst (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(push_reg),
      .in_ready(fifo_ready),
      .in_data(rxs_reg),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   // ****************************************
   // slow channels
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sa_reg <= 1'b0;
         hold_reg <= '0;
         b1_reg <= 1'b0;
         b2_reg <= 1'b0;
         e1_reg <= 1'b0;
         e2_reg <= 1'b0;
      end else begin
         b1_reg <= link.slow_output_b;
         b2_reg <= b1_reg;
         e1_reg <= link.slow_output_b_en;
         e2_reg <= e1_reg;
         // hold each slow level long enough
         if (hold_reg != '0) hold_reg <= hold_reg - 16'h0001;
         else if (slow_a_req != sa_reg) begin
            sa_reg <= slow_a_req;
            hold_reg <= SLOW_L;
         end
      end
   end
   assign link.host_select_in_n = sel_reg;
   assign link.host_clk = sck_reg;
   assign link.host_data_out = sh_reg[W-1];
   assign link.slow_input_a = sa_reg;
   assign slow_b_level = b2_reg;
   assign slow_b_valid = e2_reg;
endmodule // isr_host

// >>> sim/isr_relay_props.sv
// checker for the relay link: fast paths, delayed clock, slow exchange, watchdog
// assumes it sits beside the link interface in the bench top, one clock domain
`timescale 1ns/1ps
module isr_relay_props #(
   parameter int EXCH_HALF = 20,
   parameter int WATCHDOG = 60
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic host_clk,
   input wire logic host_data_out,
   input wire logic host_select_in_n,
   input wire logic host_data_return,
   input wire logic delayed_return_clock,
   input wire logic slow_input_a,
   input wire logic slow_output_b,
   input wire logic slow_output_b_en,
   input wire logic far_clk,
   input wire logic far_data_drive,
   input wire logic far_select_out_n,
   input wire logic far_data_return,
   input wire logic slow_output_a,
   input wire logic slow_input_b,
   input wire logic far_powered
);
   localparam int SLOW_MAX = 2 * EXCH_HALF + 16;
   localparam int DEAD_LIM = WATCHDOG + 2 * EXCH_HALF + 8;
   // fast path latency seen from the sampled input edge: sync, filter, output flop
   localparam int FAST_LAT = 4 + isr_pkg::GLITCH_CYC;
   int dead_cnt_reg;
   // counts cycles with the far side dead, saturating
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) dead_cnt_reg <= 0;
      else if (far_powered) dead_cnt_reg <= 0;
      else if (dead_cnt_reg < DEAD_LIM) dead_cnt_reg <= dead_cnt_reg + 1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ****************************************
   // fast paths
   // ****************************************
   // clock relay
   property p_clk_relay;
      $rose(host_clk) |-> ##FAST_LAT far_clk;
   endproperty
   a_clk_relay: assert property (p_clk_relay) else $error("far clock late");
   property p_data_relay;
      $changed(host_data_out) |-> ##[4:6] far_data_drive == host_data_out;
   endproperty
   a_data_relay: assert property (p_data_relay) else $error("far data wrong");
   property p_sel_relay;
      $fell(host_select_in_n) |-> ##FAST_LAT !far_select_out_n;
   endproperty
   a_sel_relay: assert property (p_sel_relay) else $error("far select late");
   property p_sel_setup;
      $fell(host_select_in_n) |-> !host_clk [*2];
   endproperty
   a_sel_setup: assert property (p_sel_setup) else $error("clock too soon");
   property p_ret_idle;
      $changed(far_data_return) && host_select_in_n |->
         ##[4:6] host_data_return == far_data_return;
   endproperty
   a_ret_idle: assert property (p_ret_idle) else $error("return not relayed");
   property p_delayed_return_clock;
      $rose(host_clk) |-> ##[10:13] delayed_return_clock;
   endproperty
   a_delayed_return_clock: assert property (p_delayed_return_clock) else $error("delayed clock missing");
   // ****************************************
   // slow exchange
   // ****************************************
   // slow pulse held
   property p_slow_hold;
      $changed(slow_input_a) |=> $stable(slow_input_a) [*8];
   endproperty
   a_slow_hold: assert property (p_slow_hold) else $error("slow pulse short");
   property p_slow_a;
      $changed(slow_input_a) |-> ##[2:SLOW_MAX] slow_output_a == slow_input_a;
   endproperty
   a_slow_a: assert property (p_slow_a) else $error("slow a not delivered");
   property p_slow_b;
      $changed(slow_input_b) && far_powered |-> ##[2:SLOW_MAX] slow_output_b == slow_input_b;
   endproperty
   a_slow_b: assert property (p_slow_b) else $error("slow b not delivered");
   property p_wdog;
      dead_cnt_reg == DEAD_LIM |-> !slow_output_b_en;
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog did not float");
endmodule // isr_relay_props

// >>> sim/isolated_spi_channel_relay_tb.sv
// bench joining host end and relay; far side loops data back to the relay
// assumes the link interface and package compile first
`timescale 1ns/1ps
module isolated_spi_channel_relay_tb;
   localparam int EXCH = 20;
   localparam int WDOG = 60;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic tx_valid = 1'b0;
   logic rx_ready = 1'b0;
   logic slow_a_req = 1'b0;
   logic slow_input_b = 1'b0;
   logic far_powered = 1'b1;
   logic loop_on = 1'b1;
   logic ret_forced = 1'b0;
   logic far_data_return = 1'b0;
   logic [isr_pkg::WORD_W-1:0] tx_data = 8'h00;
   logic [isr_pkg::WORD_W-1:0] rx_data;
   logic tx_ready, rx_valid, slow_b_level, slow_b_valid;
   logic far_clk, far_data_drive, far_select_out_n, slow_output_a, far_out_en;
   logic [isr_pkg::WORD_W-1:0] words [8] = '{8'ha5, 8'h01, 8'h80, 8'hff,
      8'h00, 8'h5a, 8'h7e, 8'hc3};
   int failures = 0;
   int n_tests = 0;
   // ****************************************
   // clock, far side, instances
   // ****************************************
   always #4 clk_sys = ~clk_sys;
   // far peripheral echoes its data input or a forced level
   always @(negedge clk_sys) far_data_return <= loop_on ? far_data_drive : ret_forced;
   isr_link_if isr_link_if_inst ();
   isr_relay #(.FILTER_GRADE(1'b1), .EXCH_HALF(EXCH), .WATCHDOG(WDOG)) isr_relay_inst (
      .clk_sys(clk_sys), .rst(rst), .link(isr_link_if_inst.dev), .far_clk(far_clk),
      .far_data_drive(far_data_drive), .far_select_out_n(far_select_out_n),
      .far_data_return(far_data_return), .slow_output_a(slow_output_a),
      .far_out_en(far_out_en), .slow_input_b(slow_input_b), .far_powered(far_powered));
   isr_host #(.HALF(8), .SLOW_MIN(50)) isr_host_inst (
      .clk_sys(clk_sys), .rst(rst), .link(isr_link_if_inst.host), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .slow_a_req(slow_a_req), .slow_b_level(slow_b_level),
      .slow_b_valid(slow_b_valid));
   isr_relay_props #(.EXCH_HALF(EXCH), .WATCHDOG(WDOG)) isr_relay_props_inst (
      .clk_sys(clk_sys), .rst(rst), .host_clk(isr_link_if_inst.host_clk),
      .host_data_out(isr_link_if_inst.host_data_out),
      .host_select_in_n(isr_link_if_inst.host_select_in_n),
      .host_data_return(isr_link_if_inst.host_data_return),
      .delayed_return_clock(isr_link_if_inst.delayed_return_clock),
      .slow_input_a(isr_link_if_inst.slow_input_a), .slow_output_b(isr_link_if_inst.slow_output_b),
      .slow_output_b_en(isr_link_if_inst.slow_output_b_en), .far_clk(far_clk),
      .far_data_drive(far_data_drive), .far_select_out_n(far_select_out_n),
      .far_data_return(far_data_return), .slow_output_a(slow_output_a),
      .slow_input_b(slow_input_b), .far_powered(far_powered));
   // ****************************************
   // compare and helper tasks
   // ****************************************
   task automatic check_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_word(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_cycles(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic complete_run();
      if (failures == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // hands one word to the host end, holding valid until taken
   task automatic send_word(input logic [7:0] w);
      int i;
      tx_valid = 1'b1;
      tx_data = w;
      for (i = 0; i < 400 && tx_ready !== 1'b1; i++) @(negedge clk_sys);
      @(negedge clk_sys);
      tx_valid = 1'b0;
      @(negedge clk_sys);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   // words echo through both paths; receive buffer fills, refuses, drains
   task automatic fill_and_drain();
      int i, k;
      for (k = 0; k < 8; k++) send_word(words[k]);
      wait_cycles(400);
      check_bit("tx_ready when full", 1'b0, tx_ready);
      for (k = 0; k < 8; k++) begin
         for (i = 0; i < 50 && rx_valid !== 1'b1; i++) @(negedge clk_sys);
         check_word("rx_data", words[k], rx_data);
         rx_ready = 1'b1;
         @(negedge clk_sys);
         rx_ready = 1'b0;
         @(negedge clk_sys);
      end
      check_bit("rx_valid when empty", 1'b0, rx_valid);
      check_bit("tx_ready after drain", 1'b1, tx_ready);
   endtask
   // return pin follows the far side while deselected
   task automatic return_idle();
      int k;
      loop_on = 1'b0;
      for (k = 0; k < 2; k++) begin
         ret_forced = ~ret_forced;
         wait_cycles(12);
         check_bit("return idle", ret_forced, isr_link_if_inst.host_data_return);
      end
      check_bit("far select idle", 1'b1, far_select_out_n);
   endtask
   // both slow channels move a level, slow a not before delivery
   task automatic slow_levels(input logic lvl);
      int i;
      slow_a_req = lvl;
      slow_input_b = lvl;
      wait_cycles(2);
      check_bit("slow a early", ~lvl, slow_output_a);
      for (i = 0; i < 6 * EXCH && (slow_output_a !== lvl || slow_b_level !== lvl); i++) begin
         @(negedge clk_sys);
      end
      check_bit("slow output a", lvl, slow_output_a);
      check_bit("slow level b", lvl, slow_b_level);
   endtask
   // far side dies: host side floats slow b but keeps return driven
   task automatic far_dead();
      int i;
      far_powered = 1'b0;
      wait_cycles(WDOG + 2 * EXCH + 20);
      check_bit("slow b enable", 1'b0, isr_link_if_inst.slow_output_b_en);
      check_bit("slow b valid", 1'b0, slow_b_valid);
      check_bit("far enable", 1'b1, far_out_en);
      ret_forced = ~ret_forced;
      wait_cycles(12);
      check_bit("return when dead", ret_forced, isr_link_if_inst.host_data_return);
      far_powered = 1'b1;
      for (i = 0; i < 6 * EXCH && slow_b_valid !== 1'b1; i++) @(negedge clk_sys);
      check_bit("slow b back", 1'b1, slow_b_valid);
   endtask
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      wait_cycles(5);
      rst = 1'b0;
      @(negedge clk_sys);
      fill_and_drain();
      return_idle();
      slow_levels(1'b1);
      slow_levels(1'b0);
      far_dead();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      complete_run();
   end
endmodule // isolated_spi_channel_relay_tb
